// >>> verification/smc_link_monitor.sv
// Purpose: link checker for the step unit
// Assumes: one clock, async active-low reset
// Notes: placed beside the link interface
`timescale 1ns/1ns
module smc_link_monitor (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Link signals
  input wire logic [15:0] instr,
  input wire logic valid,
  input wire logic load,
  input wire logic [1:0] load_sel,
  input wire logic [15:0] load_data,
  input wire logic [15:0] head,
  input wire logic [15:0] second,
  input wire logic [15:0] muldiv,
  input wire logic [15:0] helper,
  input wire logic cond,
  input wire logic done
);
  logic c;
  logic [15:0] w;
  logic [15:0] head_exp;
  logic [15:0] sec_exp;
  assign c = head[0] ^ second[0];
  assign w = head ^ (muldiv & {16{c}});
  assign head_exp = {c, w[15:1]};
  assign sec_exp = {w[0], second[15:1]};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence step_s; valid && !load && instr[15:12] == 4'hA; endsequence
  sequence crc_s; step_s ##0 instr == 16'hAADE; endsequence
  AST_CRC_COND: assert property (crc_s |=> cond == $past(c))
    else $error("crc condition wrong");
  AST_CRC_HEAD: assert property (crc_s |=> head == $past(head_exp))
    else $error("crc head wrong");
  AST_CRC_SECOND: assert property (crc_s |=> second == $past(sec_exp))
    else $error("crc second wrong");
  AST_CRC_HELD: assert property (crc_s |=> $stable(muldiv) && $stable(helper))
    else $error("helpers changed");
  AST_DONE: assert property (step_s |=> done)
    else $error("done missing");
  AST_DONE_CAUSE: assert property (done |-> $past(valid))
    else $error("done without step");
  AST_ALU_LOAD: assert property (step_s ##0 instr == 16'hAE01 |=> head == $past(muldiv))
    else $error("load op wrong");
  AST_IGNORED: assert property (valid && !load && instr[15:12] != 4'hA |=> $stable(head))
    else $error("foreign opcode acted");
  AST_LOAD_MD: assert property (load && load_sel == 2'h2 |=> muldiv == $past(load_data))
    else $error("muldiv load wrong");
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the step unit pair
// Assumes: 100 MHz clock, Avalon-MM control
// Notes: expected reads queued by the driver
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic resetn;
  logic [4:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_req;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [15:0] h, s, m, t;
  int err_total;
  int checked;
  smc_link_if link ();
  smc_step_unit u_smc_step_unit (.CLK_IN(clk), .RESETN_IN(resetn), .LINK(link));
  smc_core_side u_smc_core_side (.CLK_IN(clk), .RESETN_IN(resetn), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .LINK(link));
  smc_link_monitor u_smc_link_monitor (.CLK_IN(clk), .RESETN_IN(resetn),
    .instr(link.instr), .valid(link.valid), .load(link.load), .load_sel(link.load_sel),
    .load_data(link.load_data), .head(link.head), .second(link.second),
    .muldiv(link.muldiv), .helper(link.helper), .cond(link.cond), .done(link.done));
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (n >= 100) err_total++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] x);
    exp_q.push_back({16'h0000, x});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic ld(input logic [1:0] sel, input logic [15:0] d);
    bus(1'b1, 5'h04, {14'h0, sel, d});
  endtask
  task automatic chk_pair(input logic [31:0] x);
    rd_chk(5'h0C, x[31:16]);
    rd_chk(5'h10, x[15:0]);
  endtask
  task automatic cmp(input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED readdata expected %h seen %h", x, g);
    end
  endtask
  function automatic logic [15:0] alu_ref(input logic [2:0] op, input logic [15:0] a, b);
    logic [16:0] r;
    case (op)
      3'h1: r = {1'b1, a & b};
      3'h2: r = {1'b0, a} + {1'b0, ~b} + 17'h1;
      3'h3: r = {1'b1, a | b};
      3'h4: r = {1'b0, a} + {1'b0, b};
      3'h5: r = {1'b1, a ^ b};
      3'h6: r = {1'b0, b} + {1'b0, ~a} + 17'h1;
      3'h7: r = {1'b1, b};
      default: r = {1'b1, a};
    endcase
    return r[16] ? r[15:0] : a;
  endfunction
  function automatic logic [31:0] sh_ref(input logic [2:0] k, input logic [15:0] a, b);
    case (k)
      3'h1: return {a[14:0], 1'b1, b};
      3'h3: return {1'b1, a[15:1], b};
      3'h4: return {a, b[14:0], 1'b1};
      3'h5: return {a[14:0], b[15], b[14:0], 1'b1};
      default: return {1'b1, a[15:1], a[0], b[15:1]};
    endcase
  endfunction
  function automatic logic [31:0] crc_ref(input logic [15:0] a, b, md, input int n);
    logic c;
    for (int i = 0; i < n; i++) begin
      c = a[0] ^ b[0];
      if (c) a = a ^ md;
      b = {a[0], b[15:1]};
      a = {c, a[15:1]};
    end
    return {a, b};
  endfunction
  always @(posedge clk) begin
    if (rd && wait_req === 1'b0) cmp(exp_q.pop_front(), rdata);
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    {resetn, rd, wr, addr, wdata, err_total, checked} = '0;
    void'($urandom(90));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 3; a < 8; a++) rd_chk(5'(a * 4), 16'h0000);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      h = 16'($urandom);
      m = 16'($urandom);
      ld(2'h0, h);
      ld(2'h2, m);
      bus(1'b1, 5'h00, {16'h0, 4'hA, 3'(k), 9'h001});
      rd_chk(5'h0C, alu_ref(3'(k), h, m));
    end
    $display("alu test done");
    for (int k = 1; k < 8; k++) begin
      if (k % 4 != 2) begin
        h = 16'($urandom);
        s = 16'($urandom);
        ld(2'h0, h);
        ld(2'h1, s);
        bus(1'b1, 5'h00, {16'h0, 12'hA00, 3'(k), 1'b1});
        chk_pair(sh_ref(3'(k), h, s));
      end
    end
    $display("shift test done");
    for (int n = 8; n <= 16; n += 8) begin
      h = (n == 8) ? 16'hFFFF : 16'($urandom);
      s = 16'($urandom);
      m = (n == 8) ? 16'h8408 : 16'($urandom);
      t = 16'($urandom);
      ld(2'h0, h);
      ld(2'h1, s);
      ld(2'h2, m);
      ld(2'h3, t);
      repeat (n) bus(1'b1, 5'h00, 32'h0000AADE);
      e = crc_ref(h, s, m, n);
      chk_pair(e);
      rd_chk(5'h14, m);
      rd_chk(5'h18, t);
    end
    bus(1'b1, 5'h00, 32'h00005ADE);
    chk_pair(e);
    $display("crc test done");
    h = 16'($urandom);
    m = 16'($urandom);
    t = 16'($urandom);
    ld(2'h0, h);
    ld(2'h2, m);
    ld(2'h3, t);
    bus(1'b1, 5'h00, 32'h0000A196);
    rd_chk(5'h0C, {h[0], h[15:1]});
    rd_chk(5'h14, h[0] ? (m | t) : m);
    rd_chk(5'h18, {1'b0, t[15:1]});
    $display("helper test done");
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule

// >>> verilog/smc_consts.svh
// How it works
// - CRC step: condition is head0 xor second0
// - CRC step shifts head:second right, condition bit into head bit 15
// - Three-bit ALU field, applied when condition set
// - Two-bit field selects condition bit source
// - Select 0: helpers hold, operand is muldiv
// - Shift codes 001 to 011 on head, 000 no shift
// - Shift code 100 on second, 101 to 111 on pair
// - Listed step opcodes decode through common fields
// - Software loads reversed polynomial into muldiv
// - CRC polynomial x16+x12+x5+1, xor on one
// - Eight steps per byte, sixteen per word
// - X.25 starts all ones, inverts; Kermit zero
// - Non-reflected CRCs need software bit reversal
// Purpose: constants for the step math unit
// Assumes: 16-bit core datapath
// Notes: opcode field positions and known step opcodes
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_PREFIX 4'hA
`define SMC_PFX_HI 15
`define SMC_PFX_LO 12
`define SMC_ALU_HI 11
`define SMC_ALU_LO 9
`define SMC_RSEL 8
`define SMC_YY_HI 7
`define SMC_YY_LO 6
`define SMC_IR3 3
`define SMC_SH_HI 3
`define SMC_SH_LO 1
`define SMC_IR0 0
`define SMC_OP_CRC 16'hAADE
`define SMC_OP_SHL17 16'hA012
`define SMC_OP_UMUL 16'hA89C
`define SMC_OP_BREV 16'hA196
`define SMC_CRC_POLY_REV 16'h8408
`define SMC_CRC_INIT_X25 16'hFFFF
`define SMC_RESET_WORD 16'h0000
`endif

// >>> verilog/smc_core_side.sv
// Purpose: core-side sequencer with Avalon-MM control slave
// Assumes: software drives CRC setup through registers
// Notes: 0x0 cmd word, 0x4 load data/sel, 0x8 status, 0xC head, 0x10 second
`timescale 1ns/1ns
`include "smc_consts.svh"
module smc_core_side (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Link
  smc_link_if.core LINK
);
  typedef struct packed {
    smc_pkg::smc_core_t c;
    logic [31:0] rdata;
    logic wait_req;
  } smc_side_t;
  smc_side_t st_ff;
  smc_side_t nxt_st;
  logic req;

  always_comb begin
    nxt_st = st_ff;
    req = AVS_READ_IN || AVS_WRITE_IN;
    nxt_st.c.valid = 1'b0;
    nxt_st.c.load = 1'b0;
    nxt_st.wait_req = 1'b1;
    unique case (st_ff.c.state)
      smc_pkg::ST_IDLE: begin
        if (req) begin
          nxt_st.wait_req = 1'b0;
          nxt_st.c.state = smc_pkg::ST_RUN;
          nxt_st.rdata = 32'h00000000;
          if (AVS_WRITE_IN) begin
            unique case (AVS_ADDRESS_IN)
              5'h00: begin
                // One step per write; CRC needs eight per byte
                nxt_st.c.instr = AVS_WRITEDATA_IN[15:0];
                nxt_st.c.valid = 1'b1;
              end
              5'h04: begin
                nxt_st.c.load_data = AVS_WRITEDATA_IN[15:0];
                nxt_st.c.load_sel = AVS_WRITEDATA_IN[17:16];
                nxt_st.c.load = 1'b1;
              end
              default: nxt_st.rdata = 32'h00000000;
            endcase
          end else begin
            unique case (AVS_ADDRESS_IN)
              5'h00: nxt_st.rdata = {16'h0000, st_ff.c.instr};
              5'h08: nxt_st.rdata = {30'h00000000, LINK.done, LINK.cond};
              5'h0C: nxt_st.rdata = {16'h0000, LINK.head};
              5'h10: nxt_st.rdata = {16'h0000, LINK.second};
              5'h14: nxt_st.rdata = {16'h0000, LINK.muldiv};
              5'h18: nxt_st.rdata = {16'h0000, LINK.helper};
              default: nxt_st.rdata = 32'h00000000;
            endcase
          end
        end
      end
      smc_pkg::ST_RUN: nxt_st.c.state = smc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_ff <= '0;
      // Waitrequest stands high through reset
      st_ff.wait_req <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign LINK.instr = st_ff.c.instr;
  assign LINK.valid = st_ff.c.valid;
  assign LINK.load = st_ff.c.load;
  assign LINK.load_sel = st_ff.c.load_sel;
  assign LINK.load_data = st_ff.c.load_data;
  assign AVS_READDATA_OUT = st_ff.rdata;
  assign AVS_WAITREQUEST_OUT = st_ff.wait_req;
endmodule

// >>> verilog/smc_link_if.sv
// Purpose: carrier between core side and step unit
// Assumes: one clock
// Notes: load_sel 0 head, 1 second, 2 muldiv, 3 helper
`timescale 1ns/1ns
interface smc_link_if;
  logic [15:0] instr;
  logic valid;
  logic load;
  logic [1:0] load_sel;
  logic [15:0] load_data;
  logic [15:0] head;
  logic [15:0] second;
  logic [15:0] muldiv;
  logic [15:0] helper;
  logic cond;
  logic done;
  modport unit (input instr, valid, load, load_sel, load_data,
                output head, second, muldiv, helper, cond, done);
  modport core (output instr, valid, load, load_sel, load_data,
                input head, second, muldiv, helper, cond, done);
endinterface

// >>> verilog/smc_pkg.sv
// Purpose: types for the step math unit
// Assumes: nothing
// Notes: ALU and shift enums follow the opcode field encodings
package smc_pkg;
  typedef enum logic [2:0] {
    ALU_NONE, ALU_AND, ALU_SUB, ALU_OR, ALU_ADD, ALU_XOR, ALU_RSUB, ALU_LOAD
  } smc_alu_t;
  typedef enum logic [2:0] {
    SH_NONE, SH_HEAD_L, SH_HEAD_RS, SH_HEAD_RC,
    SH_SECOND_L, SH_PAIR_L, SH_PAIR_RS, SH_PAIR_RC
  } smc_shift_t;
  typedef enum logic {
    ST_IDLE, ST_RUN
  } smc_state_t;
  typedef struct packed {
    logic [15:0] head;
    logic [15:0] second;
    logic [15:0] muldiv_operand_reg;
    logic [15:0] root_helper_reg;
    logic extended_carry_hi;
    logic extended_carry_lo;
    logic step_condition_bit;
    logic done;
  } smc_unit_t;
  typedef struct packed {
    smc_state_t state;
    logic [15:0] instr;
    logic valid;
    logic [15:0] load_data;
    logic [1:0] load_sel;
    logic load;
  } smc_core_t;
endpackage

// >>> verilog/smc_step_unit.sv
// Purpose: single-cycle step math datapath with CRC step
// Assumes: core issues one step or load per valid cycle
// Notes: state registers other than the two extended carry bits are the link outputs
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "smc_consts.svh"
module smc_step_unit (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Link
  smc_link_if.unit LINK
);
  smc_pkg::smc_unit_t st_ff;
  smc_pkg::smc_unit_t nxt_st;
  logic [15:0] ir;
  smc_pkg::smc_alu_t alu_op;
  smc_pkg::smc_shift_t sh_op;
  logic rsel;
  logic [1:0] yy;
  logic [15:0] operand;
  logic [17:0] w;
  logic [16:0] sum;
  logic arith;
  logic base_cond;
  logic cond;
  logic step_ok;

  always_comb begin
    ir = LINK.instr;
    alu_op = smc_pkg::smc_alu_t'(ir[`SMC_ALU_HI:`SMC_ALU_LO]);
    sh_op = smc_pkg::smc_shift_t'(ir[`SMC_SH_HI:`SMC_SH_LO]);
    rsel = ir[`SMC_RSEL];
    yy = ir[`SMC_YY_HI:`SMC_YY_LO];
    step_ok = LINK.valid && (ir[`SMC_PFX_HI:`SMC_PFX_LO] == `SMC_PREFIX);
    // Helper operand when select set, muldiv otherwise
    operand = rsel ? st_ff.root_helper_reg : st_ff.muldiv_operand_reg;
    arith = (alu_op == smc_pkg::ALU_SUB) || (alu_op == smc_pkg::ALU_ADD) ||
            (alu_op == smc_pkg::ALU_RSUB);
    unique case (alu_op)
      smc_pkg::ALU_SUB: sum = {1'b0, st_ff.head} + {1'b0, ~operand} + 17'h00001;
      smc_pkg::ALU_RSUB: sum = {1'b0, operand} + {1'b0, ~st_ff.head} + 17'h00001;
      default: sum = {1'b0, st_ff.head} + {1'b0, operand};
    endcase
    base_cond = arith ? sum[16] : ir[`SMC_IR0];
    unique case (yy)
      2'h0: cond = base_cond;
      2'h1: cond = base_cond | st_ff.extended_carry_hi;
      2'h2: cond = ir[`SMC_IR3] ? st_ff.second[0] : st_ff.head[0];
      default: cond = st_ff.head[0] ^ st_ff.second[0];
    endcase
    w = {st_ff.extended_carry_hi, st_ff.extended_carry_lo, st_ff.head};
    if (cond) begin
      unique case (alu_op)
        smc_pkg::ALU_NONE: w = w;
        smc_pkg::ALU_AND: w[15:0] = st_ff.head & operand;
        smc_pkg::ALU_SUB: w = {sum[16], sum[16], sum[15:0]};
        smc_pkg::ALU_OR: w[15:0] = st_ff.head | operand;
        smc_pkg::ALU_ADD: w = {sum[16], sum[16], sum[15:0]};
        smc_pkg::ALU_XOR: w[15:0] = st_ff.head ^ operand;
        smc_pkg::ALU_RSUB: w = {sum[16], sum[16], sum[15:0]};
        smc_pkg::ALU_LOAD: w[15:0] = operand;
      endcase
    end
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (LINK.load) begin
      unique case (LINK.load_sel)
        2'h0: nxt_st.head = LINK.load_data;
        2'h1: nxt_st.second = LINK.load_data;
        2'h2: nxt_st.muldiv_operand_reg = LINK.load_data;
        default: nxt_st.root_helper_reg = LINK.load_data;
      endcase
    end else if (step_ok) begin
      // All updates commit together at this edge
      nxt_st.done = 1'b1;
      nxt_st.step_condition_bit = cond;
      unique case (sh_op)
        smc_pkg::SH_NONE: {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo,
          nxt_st.head} = w;
        smc_pkg::SH_HEAD_L: {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo,
          nxt_st.head} = {w[16:0], cond};
        smc_pkg::SH_HEAD_RS: {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo,
          nxt_st.head} = {w[17], w[17], w[16:1]};
        smc_pkg::SH_HEAD_RC: {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo,
          nxt_st.head} = {w[17], w[17], cond, w[15:1]};
        smc_pkg::SH_SECOND_L: begin
          {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo, nxt_st.head} = w;
          nxt_st.second = {st_ff.second[14:0], cond};
        end
        smc_pkg::SH_PAIR_L: begin
          {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo, nxt_st.head} =
            {w[16:0], st_ff.second[15]};
          nxt_st.second = {st_ff.second[14:0], cond};
        end
        smc_pkg::SH_PAIR_RS: begin
          {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo, nxt_st.head} =
            {w[17], w[17], w[16:1]};
          nxt_st.second = {w[0], st_ff.second[15:1]};
        end
        smc_pkg::SH_PAIR_RC: begin
          // CRC step lands here with condition bit into head bit 15
          {nxt_st.extended_carry_hi, nxt_st.extended_carry_lo, nxt_st.head} =
            {w[17], w[17], cond, w[15:1]};
          nxt_st.second = {w[0], st_ff.second[15:1]};
        end
      endcase
      if (rsel) begin
        nxt_st.root_helper_reg = {1'b0, st_ff.root_helper_reg[15:1]};
        if (cond) begin
          nxt_st.muldiv_operand_reg = st_ff.muldiv_operand_reg |
            st_ff.root_helper_reg;
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign LINK.head = st_ff.head;
  assign LINK.second = st_ff.second;
  assign LINK.muldiv = st_ff.muldiv_operand_reg;
  assign LINK.helper = st_ff.root_helper_reg;
  assign LINK.cond = st_ff.step_condition_bit;
  assign LINK.done = st_ff.done;
endmodule
